// ---- nfc_pkg.sv ----
// Constants, types and command sequences of the NAND flash host controller
`default_nettype none
package nfc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int T_CLS_NS = 12;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_WB_NS = 100;
  localparam int T_WW_NS = 100;
  localparam logic [3:0] SETUP_CYC = 4'((T_CLS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WH_CYC = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  // Access time is a maximum, so the sample waits it out in full
  localparam logic [3:0] REA_CYC = 4'((T_REA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] REH_CYC = 4'((T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WB_CYC = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WW_CYC = 4'((T_WW_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // Geometry and status
  // ****************************************************************
  localparam logic [12:0] PAGE_BYTES = 13'h0840;
  localparam logic [15:0] PAGE_MASK = 16'h003f;
  localparam int BLOCK_LSB = 6;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;

  // ****************************************************************
  // Commands
  // ****************************************************************
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_RCOL1 = 8'h05;
  localparam logic [7:0] CMD_RCOL2 = 8'he0;
  localparam logic [7:0] CMD_PLOAD = 8'h80;
  localparam logic [7:0] CMD_PCOL = 8'h85;
  localparam logic [7:0] CMD_PCONF = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ, OP_RCOL, OP_PLOAD, OP_PCOL,
    OP_PCONF, OP_ERASE, OP_STATUS, OP_RESET
  } nfc_op_e;
  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_WR, CYC_RD} nfc_cyc_e;
  typedef enum logic [2:0] {
    K_CMD, K_ADDR, K_WR, K_RD, K_WAIT, K_STAT, K_END
  } nfc_step_e;

  // ****************************************************************
  // Step lists, nine per operation in operation order
  // ****************************************************************
  localparam int SEQ_LEN = 9;
  localparam logic [10:0] S_A0 = {K_ADDR, 8'h00};
  localparam logic [10:0] S_A1 = {K_ADDR, 8'h01};
  localparam logic [10:0] S_A2 = {K_ADDR, 8'h02};
  localparam logic [10:0] S_A3 = {K_ADDR, 8'h03};
  localparam logic [10:0] S_WR = {K_WR, 8'h00};
  localparam logic [10:0] S_RD = {K_RD, 8'h00};
  localparam logic [10:0] S_WT = {K_WAIT, 8'h00};
  localparam logic [10:0] S_ST = {K_STAT, 8'h00};
  localparam logic [10:0] S_EN = {K_END, 8'h00};
  localparam logic [10:0] S_STA = {K_CMD, CMD_STATUS};
  localparam logic [10:0] SEQ [0:71] = '{
    {K_CMD, CMD_READ1}, S_A0, S_A1, S_A2, S_A3,
    {K_CMD, CMD_READ2}, S_WT, S_RD, S_EN,
    {K_CMD, CMD_RCOL1}, S_A0, S_A1, {K_CMD, CMD_RCOL2},
    S_WT, S_RD, S_EN, S_EN, S_EN,
    {K_CMD, CMD_PLOAD}, S_A0, S_A1, S_A2, S_A3,
    S_WR, S_EN, S_EN, S_EN,
    {K_CMD, CMD_PCOL}, S_A0, S_A1, S_WR, S_EN,
    S_EN, S_EN, S_EN, S_EN,
    {K_CMD, CMD_PCONF}, S_WT, S_STA, S_WT, S_ST,
    S_EN, S_EN, S_EN, S_EN,
    {K_CMD, CMD_ERASE1}, S_A2, S_A3, {K_CMD, CMD_ERASE2},
    S_WT, S_STA, S_WT, S_ST, S_EN,
    S_STA, S_WT, S_ST, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN,
    {K_CMD, CMD_RESET}, S_WT, S_EN, S_EN, S_EN,
    S_EN, S_EN, S_EN, S_EN
  };

endpackage
`default_nettype wire

// ---- nfc_byte_cycle.sv ----
// One command, address, write or read byte cycle on the flash pins
`timescale 1ns/100ps
`default_nettype none
module nfc_byte_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic done,
  // Pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in
);

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_LOW, PH_HIGH} nfc_ph_e;
  typedef struct packed {
    nfc_ph_e ph;
    logic [3:0] cnt;
    logic rd;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic [7:0] io_out;
    logic io_oe;
    logic [7:0] dout;
    logic done;
  } nfc_bc_s;

  nfc_bc_s q;
  nfc_bc_s d;
  nfc_pkg::nfc_cyc_e k;

  assign k = nfc_pkg::nfc_cyc_e'(kind);

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.ph)
      PH_IDLE: begin
        if (start) begin
          d.ph = PH_SETUP;
          d.cnt = nfc_pkg::SETUP_CYC - 4'h1;
          d.rd = (k == nfc_pkg::CYC_RD);
          d.cle = (k == nfc_pkg::CYC_CMD);
          d.ale = (k == nfc_pkg::CYC_ADDR);
          d.io_out = din;
          d.io_oe = (k != nfc_pkg::CYC_RD);
        end
      end
      PH_SETUP: begin
        if (q.cnt == 4'h0) begin
          d.ph = PH_LOW;
          if (q.rd) begin
            d.cnt = nfc_pkg::REA_CYC - 4'h1;
            d.output_strobe_n = 1'b0;
          end else begin
            d.cnt = nfc_pkg::WP_CYC - 4'h1;
            d.we_n = 1'b0;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      PH_LOW: begin
        if (q.cnt == 4'h0) begin
          d.ph = PH_HIGH;
          d.cnt = q.rd ? nfc_pkg::REH_CYC - 4'h1 : nfc_pkg::WH_CYC - 4'h1;
          // Rising write strobe is the latch edge for the device
          d.we_n = 1'b1;
          d.output_strobe_n = 1'b1;
          if (q.rd) begin
            d.dout = io_in;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        // Latches and data held through the high phase for hold time
        if (q.cnt == 4'h0) begin
          d.ph = PH_IDLE;
          d.done = 1'b1;
          d.cle = 1'b0;
          d.ale = 1'b0;
          d.io_oe = 1'b0;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
    if (sys_rst) begin
      d = '0;
      d.we_n = 1'b1;
      d.output_strobe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.dout;
  assign done = q.done;
  assign cle = q.cle;
  assign ale = q.ale;
  assign we_n = q.we_n;
  assign output_strobe_n = q.output_strobe_n;
  assign io_out = q.io_out;
  assign io_oe = q.io_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cmd_pulse;
    (cle && !ale && !we_n)[*2] ##1 (cle && we_n);
  endsequence
  sequence s_addr_pulse;
    (ale && !cle && !we_n)[*2] ##1 (ale && we_n);
  endsequence
  sequence s_read_pulse;
    (!output_strobe_n && !io_oe)[*3] ##1 output_strobe_n ##2 done;
  endsequence

  chk_cmd_latch: assert property (
    $fell(we_n) && cle |-> s_cmd_pulse)
    else $error("command strobe malformed");
  chk_addr_latch: assert property (
    $fell(we_n) && ale |-> s_addr_pulse)
    else $error("address strobe malformed");
  chk_read_pulse: assert property (
    $fell(output_strobe_n) |-> s_read_pulse)
    else $error("read strobe malformed");
  chk_cycle_excl: assert property (
    !(cle && ale) && (we_n || output_strobe_n) &&
    !(io_oe && !output_strobe_n))
    else $error("pin cycle type conflict");
  chk_cycle_done: assert property (
    start && q.ph == PH_IDLE |-> ##[7:8] done)
    else $error("byte cycle did not finish");

endmodule
`default_nettype wire

// ---- nfc_host.sv ----
// Host controller that runs read, program, erase, status and reset on flash
`timescale 1ns/100ps
`default_nettype none
module nfc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Operation request and result
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [11:0] op_col,
  input wire logic [15:0] op_row,
  input wire logic [12:0] op_len,
  input wire logic prot_off,
  output logic op_ready,
  output logic op_done,
  output logic op_refused,
  output logic op_fail,
  output logic [7:0] op_status,
  // Write data stream
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read data stream
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_STEP, ST_PHY, ST_WAITB, ST_BUSY
  } nfc_st_e;
  typedef struct packed {
    nfc_st_e st;
    nfc_pkg::nfc_op_e op;
    logic [3:0] idx;
    logic [11:0] col;
    logic [15:0] row;
    logic [12:0] len;
    logic [12:0] cnt;
    logic [3:0] wcnt;
    logic [3:0] wwcnt;
    logic [15:0] pp_row;
    logic [2:0] pp_cnt;
    logic ce_n;
    logic wp_n;
    logic op_ready;
    logic done;
    logic refused;
    logic fail;
    logic [7:0] status;
    logic wr_take;
    logic rd_valid;
    logic [7:0] rd_data;
    logic start;
    nfc_pkg::nfc_cyc_e cyc;
    logic [7:0] bval;
  } nfc_host_s;

  nfc_host_s q;
  nfc_host_s d;
  nfc_pkg::nfc_op_e op_in;
  logic [7:0] phy_dout;
  logic phy_done;
  logic is_prot;
  logic is_col;
  logic bad_busy;
  logic bad_wp;
  logic bad_col;
  logic bad_pp;

  function automatic logic [10:0] seq_at(nfc_pkg::nfc_op_e op,
                                         logic [3:0] i);
    seq_at = nfc_pkg::SEQ[7'(op) * 7'(nfc_pkg::SEQ_LEN) + 7'(i)];
  endfunction

  function automatic logic [7:0] addr_byte(logic [11:0] col,
                                           logic [15:0] row,
                                           logic [1:0] i);
    case (i)
      2'h0: addr_byte = col[7:0];
      2'h1: addr_byte = {4'h0, col[11:8]};
      2'h2: addr_byte = row[7:0];
      default: addr_byte = row[15:8];
    endcase
  endfunction

  function automatic logic [9:0] block_of(logic [15:0] row);
    block_of = row[15:nfc_pkg::BLOCK_LSB];
  endfunction

  // ****************************************************************
  // Request screening
  // ****************************************************************
  assign op_in = nfc_pkg::nfc_op_e'(op_code);
  assign is_prot = op_in inside {nfc_pkg::OP_PLOAD, nfc_pkg::OP_PCOL,
                                 nfc_pkg::OP_PCONF, nfc_pkg::OP_ERASE};
  assign is_col = op_in inside {nfc_pkg::OP_READ, nfc_pkg::OP_RCOL,
                                nfc_pkg::OP_PLOAD, nfc_pkg::OP_PCOL};
  assign bad_busy = !ready_busy_n &&
                    !(op_in inside {nfc_pkg::OP_STATUS, nfc_pkg::OP_RESET});
  // Write guard must have been high long enough before the first strobe
  assign bad_wp = is_prot && (!q.wp_n || q.wwcnt != nfc_pkg::WW_CYC);
  assign bad_col = is_col &&
    ({1'b0, op_col} >= nfc_pkg::PAGE_BYTES ||
     14'(op_col) + 14'(op_len) > 14'(nfc_pkg::PAGE_BYTES));
  assign bad_pp = op_in == nfc_pkg::OP_PCONF && q.row == q.pp_row &&
                  q.pp_cnt == nfc_pkg::MAX_PARTIAL;

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  always_comb begin
    logic [10:0] s;
    nfc_pkg::nfc_step_e kind;
    s = seq_at(q.op, q.idx);
    kind = nfc_pkg::nfc_step_e'(s[10:8]);
    d = q;
    d.start = 1'b0;
    d.done = 1'b0;
    d.refused = 1'b0;
    d.wr_take = 1'b0;
    d.rd_valid = 1'b0;
    d.wp_n = prot_off;
    if (!q.wp_n) begin
      d.wwcnt = 4'h0;
    end else if (q.wwcnt != nfc_pkg::WW_CYC) begin
      d.wwcnt = q.wwcnt + 4'h1;
    end
    case (q.st)
      ST_IDLE: begin
        if (op_valid) begin
          if (bad_busy || bad_wp || bad_col || bad_pp) begin
            d.done = 1'b1;
            d.refused = 1'b1;
          end else begin
            d.st = ST_STEP;
            d.op = op_in;
            d.idx = 4'h0;
            d.cnt = 13'h0000;
            d.len = op_len;
            d.op_ready = 1'b0;
            d.ce_n = 1'b0;
            if (is_col) begin
              d.col = op_col;
            end
            if (op_in inside {nfc_pkg::OP_READ, nfc_pkg::OP_PLOAD}) begin
              d.row = op_row;
            end
            if (op_in == nfc_pkg::OP_ERASE) begin
              d.row = op_row & ~nfc_pkg::PAGE_MASK;
              if (block_of(op_row) == block_of(q.pp_row)) begin
                d.pp_cnt = 3'h0;
              end
            end
            if (op_in == nfc_pkg::OP_PCONF) begin
              if (q.row == q.pp_row) begin
                d.pp_cnt = q.pp_cnt + 3'h1;
              end else begin
                d.pp_row = q.row;
                d.pp_cnt = 3'h1;
              end
            end
          end
        end
      end
      ST_STEP: begin
        case (kind)
          nfc_pkg::K_CMD: begin
            d.start = 1'b1;
            d.cyc = nfc_pkg::CYC_CMD;
            d.bval = s[7:0];
            d.st = ST_PHY;
          end
          nfc_pkg::K_ADDR: begin
            d.start = 1'b1;
            d.cyc = nfc_pkg::CYC_ADDR;
            d.bval = addr_byte(q.col, q.row, s[1:0]);
            d.st = ST_PHY;
          end
          nfc_pkg::K_WR: begin
            if (q.cnt == q.len) begin
              d.idx = q.idx + 4'h1;
            end else if (wr_valid) begin
              d.start = 1'b1;
              d.cyc = nfc_pkg::CYC_WR;
              d.bval = wr_data;
              d.wr_take = 1'b1;
              d.st = ST_PHY;
            end
          end
          nfc_pkg::K_RD, nfc_pkg::K_STAT: begin
            if (kind == nfc_pkg::K_RD && q.cnt == q.len) begin
              d.idx = q.idx + 4'h1;
            end else begin
              d.start = 1'b1;
              d.cyc = nfc_pkg::CYC_RD;
              d.st = ST_PHY;
            end
          end
          nfc_pkg::K_WAIT: begin
            d.wcnt = nfc_pkg::WB_CYC - 4'h1;
            d.st = ST_WAITB;
          end
          default: begin
            // Chip select high on completion lets the device idle
            d.ce_n = 1'b1;
            d.done = 1'b1;
            d.op_ready = 1'b1;
            d.st = ST_IDLE;
          end
        endcase
      end
      ST_PHY: begin
        if (phy_done) begin
          d.st = ST_STEP;
          if (kind == nfc_pkg::K_WR || kind == nfc_pkg::K_RD) begin
            d.cnt = q.cnt + 13'h0001;
          end else begin
            d.idx = q.idx + 4'h1;
          end
          if (kind == nfc_pkg::K_RD) begin
            d.rd_valid = 1'b1;
            d.rd_data = phy_dout;
          end
          if (kind == nfc_pkg::K_STAT) begin
            d.status = phy_dout;
            d.fail = phy_dout[nfc_pkg::ST_FAIL_BIT];
          end
        end
      end
      ST_WAITB: begin
        if (q.wcnt == 4'h0) begin
          d.st = ST_BUSY;
        end else begin
          d.wcnt = q.wcnt - 4'h1;
        end
      end
      default: begin
        // Strobes stay high here; only ready ends the wait
        if (ready_busy_n) begin
          d.idx = q.idx + 4'h1;
          d.st = ST_STEP;
        end
      end
    endcase
    if (sys_rst) begin
      d = '0;
      d.ce_n = 1'b1;
      d.op_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  nfc_byte_cycle u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(q.start),
    .kind(q.cyc),
    .din(q.bval),
    .dout(phy_dout),
    .done(phy_done),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .output_strobe_n(output_strobe_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in(io_in)
  );

  assign op_ready = q.op_ready;
  assign op_done = q.done;
  assign op_refused = q.refused;
  assign op_fail = q.fail;
  assign op_status = q.status;
  assign wr_take = q.wr_take;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign ce_n = q.ce_n;
  assign wp_n = q.wp_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_busy_refuse: assert property (
    q.st == ST_IDLE && op_valid && !ready_busy_n &&
    op_code != 3'(nfc_pkg::OP_STATUS) && op_code != 3'(nfc_pkg::OP_RESET)
    |=> op_done && op_refused && ce_n)
    else $error("command issued while busy");
  chk_guard_refuse: assert property (
    q.st == ST_IDLE && op_valid && !wp_n &&
    op_code == 3'(nfc_pkg::OP_ERASE) |=> op_refused)
    else $error("erase issued with write guard low");
  chk_busy_quiet: assert property (
    q.st == ST_BUSY |-> we_n && output_strobe_n && !ce_n)
    else $error("strobe moved during busy");
  chk_busy_hold: assert property (
    q.st == ST_BUSY && !ready_busy_n |=> q.st == ST_BUSY)
    else $error("left busy wait before ready");
  chk_ce_standby: assert property (
    $rose(ce_n) |-> op_done && op_ready)
    else $error("chip select dropped mid operation");

endmodule
`default_nettype wire

// ---- nfc_flash_model.sv ----
// Behavioural model of the flash device as seen at its pins
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model #(
  parameter int BUSY_NS = 400
) (
  // Control pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic wp_n,
  input wire logic fail_next,
  // Data and status
  input wire logic [7:0] io_host,
  output logic [7:0] io_dev,
  output logic pull_low
);
  logic [7:0] mem [logic [27:0]];
  logic [7:0] pend [logic [11:0]];
  logic [27:0] dl [$];
  logic [27:0] key;
  logic [7:0] cmd = 8'h00;
  logic [11:0] col_addr = 12'h000;
  logic [15:0] row_addr = 16'h0000;
  logic busy = 1'b0;
  logic fail = 1'b0;
  logic stat_mode = 1'b0;
  logic standby;
  int na = 0;
  assign standby = ce_n && !busy;
  assign pull_low = busy;
  initial io_dev = 8'h00;

  task automatic go_busy();
    fork
      begin
        #50 busy = 1'b1;
        #(BUSY_NS) busy = 1'b0;
      end
    join_none
  endtask

  // ****************************************
  // Byte capture on input strobe rise
  // ****************************************
  always @(posedge we_n) begin
    if (!ce_n && cle && !ale) begin
      if (!busy || io_host == 8'h70 || io_host == 8'hff) begin
        if (io_host != 8'h85 && io_host != 8'h70) stat_mode = 1'b0;
        case (io_host)
          8'h00, 8'h05, 8'h60: begin
            cmd = io_host;
            na = (io_host == 8'h60) ? 2 : 0;
          end
          8'h80: if (wp_n) begin
            cmd = 8'h80;
            na = 0;
            pend.delete();
          end
          8'h85: if (cmd == 8'h80) na = 0;
          8'h30: if (cmd == 8'h00) begin
            cmd = 8'h30;
            go_busy();
          end
          8'he0: if (cmd == 8'h05) cmd = 8'h30;
          8'h10: if (cmd == 8'h80 && wp_n) begin
            fail = fail_next;
            if (!fail) foreach (pend[c]) mem[{row_addr, c}] = pend[c];
            cmd = 8'h10;
            go_busy();
          end
          8'hd0: if (cmd == 8'h60 && wp_n) begin
            dl.delete();
            foreach (mem[k]) if (k[27:18] == row_addr[15:6]) dl.push_back(k);
            foreach (dl[i]) mem.delete(dl[i]);
            fail = 1'b0;
            cmd = 8'hd0;
            go_busy();
          end
          8'h70: stat_mode = 1'b1;
          8'hff: begin
            cmd = 8'h00;
            fail = 1'b0;
            go_busy();
          end
          default: ;
        endcase
      end
    end else if (!ce_n && ale && !cle) begin
      case (na)
        0: col_addr[7:0] = io_host;
        1: col_addr[11:8] = io_host[3:0];
        2: row_addr[7:0] = io_host;
        default: row_addr[15:8] = io_host;
      endcase
      na++;
    end else if (!ce_n && !cle && !ale && cmd == 8'h80 && wp_n) begin
      if (col_addr < 12'd2112) pend[col_addr] = io_host;
      col_addr++;
    end
  end

  // ****************************************
  // Serial output; a released bus shows junk
  // ****************************************
  always @(negedge output_strobe_n) begin
    if (!ce_n && !cle && !ale) begin
      key = {row_addr, col_addr};
      if (!stat_mode) col_addr++;
      io_dev = ~io_dev;
      #18;
      if (stat_mode) io_dev = {wp_n, !busy, 5'h00, fail};
      else io_dev = mem.exists(key) ? mem[key] : 8'hff;
    end
  end
  always @(posedge output_strobe_n) #25 io_dev = ~io_dev;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [2:0] op;
    logic [11:0] col;
    logic [15:0] row;
    logic [12:0] len;
    logic fl;
    logic rf;
  } nfc_row_s;
  localparam nfc_row_s ROWS [0:13] = '{
    '{3'h5, 12'h000, 16'h0047, 13'h0, 1'b0, 1'b0},
    '{3'h2, 12'h000, 16'h0045, 13'h4, 1'b0, 1'b0},
    '{3'h3, 12'h83c, 16'h0045, 13'h4, 1'b0, 1'b0},
    '{3'h4, 12'h000, 16'h0045, 13'h0, 1'b0, 1'b0},
    '{3'h0, 12'h000, 16'h0045, 13'h4, 1'b0, 1'b0},
    '{3'h1, 12'h83c, 16'h0045, 13'h4, 1'b0, 1'b0},
    '{3'h0, 12'h064, 16'h0045, 13'h2, 1'b0, 1'b0},
    '{3'h0, 12'h83e, 16'h0045, 13'h3, 1'b0, 1'b1},
    '{3'h2, 12'h200, 16'h0046, 13'h2, 1'b0, 1'b0},
    '{3'h4, 12'h000, 16'h0046, 13'h0, 1'b1, 1'b0},
    '{3'h6, 12'h000, 16'h0000, 13'h0, 1'b1, 1'b0},
    '{3'h0, 12'h200, 16'h0046, 13'h2, 1'b0, 1'b0},
    '{3'h7, 12'h000, 16'h0000, 13'h0, 1'b0, 1'b0},
    '{3'h6, 12'h000, 16'h0000, 13'h0, 1'b0, 1'b0}
  };
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [11:0] op_col = 12'h000;
  logic [15:0] op_row = 16'h0000;
  logic [12:0] op_len = 13'h0000;
  logic prot_off = 1'b1;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic fail_next = 1'b0;
  logic op_ready, op_done, op_refused, op_fail, wr_take, rd_valid;
  logic [7:0] op_status, rd_data, io_out, io_in, io_dev;
  logic ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe, pull_low;
  logic ready_busy_n;
  logic [7:0] exp_mem [logic [27:0]];
  logic [7:0] pend [logic [11:0]];
  logic [27:0] dl [$];
  logic [15:0] prow = 16'h0000;
  logic [15:0] rrow = 16'h0000;
  int mismatches = 0;
  int num_checks = 0;

  always #4 clk = ~clk;
  // Pull-up holds the line high unless the device sinks it
  assign ready_busy_n = !pull_low;
  assign io_in = io_oe ? io_out : io_dev;

  nfc_host nfc_host_i (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .op_col(op_col), .op_row(op_row), .op_len(op_len),
    .prot_off(prot_off), .op_ready(op_ready), .op_done(op_done),
    .op_refused(op_refused), .op_fail(op_fail), .op_status(op_status),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_take(wr_take),
    .rd_valid(rd_valid), .rd_data(rd_data), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nfc_flash_model nfc_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n),
    .fail_next(fail_next), .io_host(io_in), .io_dev(io_dev),
    .pull_low(pull_low));

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // One operation with its data streams
  // ****************************************
  task automatic do_op(input nfc_row_s r);
    int n;
    int k;
    logic [11:0] c;
    logic [7:0] e;
    n = 0;
    k = 0;
    fail_next = r.fl;
    op_code = r.op;
    op_col = r.col;
    op_row = r.row;
    op_len = r.len;
    op_valid = 1'b1;
    if (r.op == 3'h2 && !r.rf) prow = r.row;
    if (r.op == 3'h2) pend.delete();
    if (r.op == 3'h0) rrow = r.row;
    wr_valid = r.op inside {3'h2, 3'h3} && r.len != 0 && !r.rf;
    wr_data = r.col[7:0] ^ 8'ha5;
    do begin
      @(posedge clk);
      #1;
      n++;
      op_valid = 1'b0;
      c = r.col + k[11:0];
      if (wr_take === 1'b1) begin
        pend[c] = wr_data;
        k++;
        wr_data = (r.col[7:0] + k[7:0]) ^ 8'ha5;
        wr_valid = k < r.len;
      end
      if (rd_valid === 1'b1) begin
        e = exp_mem.exists({rrow, c}) ? exp_mem[{rrow, c}] : 8'hff;
        chk({8'h00, rd_data}, {8'h00, e});
        k++;
      end
    end while (op_done !== 1'b1 && n < 20000);
    chk({15'h0, op_done}, 16'h0001);
    chk({15'h0, nfc_flash_model_i.standby}, 16'h0001);
    chk({15'h0, op_refused}, {15'h0, r.rf});
    if (!r.rf && r.op < 3'h4) chk(k[15:0], {3'h0, r.len});
    if (!r.rf && r.op inside {3'h4, 3'h5, 3'h6}) begin
      chk({8'h00, op_status & 8'h41}, {9'h000, 1'b1, 5'h00, r.fl});
      chk({15'h0, op_fail}, {15'h0, r.fl});
    end
    if (r.op == 3'h4 && !r.rf && !r.fl)
      foreach (pend[p]) exp_mem[{prow, p}] = pend[p];
    if (r.op == 3'h5 && !r.rf) begin
      dl.delete();
      foreach (exp_mem[a]) if (a[27:18] == r.row[15:6]) dl.push_back(a);
      foreach (dl[i]) exp_mem.delete(dl[i]);
    end
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({ce_n, cle, ale, we_n, output_strobe_n, io_oe, wp_n, op_ready},
        16'h0099);
    sys_rst = 1'b0;
    do_op('{3'h2, 12'h000, 16'h0045, 13'h4, 1'b0, 1'b1});
    repeat (16) @(posedge clk);
    #1;
  endtask

  // Data input while the device is busy would corrupt its state
  always @(negedge we_n)
    if (ready_busy_n === 1'b0 && ce_n === 1'b0)
      chk({15'h0, cle}, 16'h0001);

  initial begin
    do_reset();
    foreach (ROWS[i]) do_op(ROWS[i]);
    for (int i = 0; i < 5; i++) begin
      do_op('{3'h2, 12'(2 * i), 16'h0080, 13'h2, 1'b0, 1'b0});
      do_op('{3'h4, 12'h000, 16'h0080, 13'h0, 1'b0, i == 4});
    end
    prot_off = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    do_op('{3'h5, 12'h000, 16'h0040, 13'h0, 1'b0, 1'b1});
    prot_off = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    do_op('{3'h5, 12'h000, 16'h0040, 13'h0, 1'b0, 1'b0});
    do_op('{3'h0, 12'h000, 16'h0045, 13'h4, 1'b0, 1'b0});
    do_reset();
    complete_run();
  end

  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
